// [hdl/dtr_defs.svh]
// Purpose: offsets, field positions, reset values and timing counts of the relay timers
// Assumes: 32-bit AXI4-Lite register words, one aligned word per register
// Notes: times are held as hours, minutes, seconds and hundredths of a second
`ifndef DTR_DEFS_SVH
`define DTR_DEFS_SVH

// register byte offsets
`define DTR_REG_OFFD_T 8'h00
`define DTR_REG_ONF_TH 8'h04
`define DTR_REG_ONF_TL 8'h08
`define DTR_REG_PLS_T 8'h0C
`define DTR_REG_BLK_TH 8'h10
`define DTR_REG_BLK_TL 8'h14
`define DTR_REG_STATUS 8'h18
`define DTR_REG_VAL_OFFD 8'h20
`define DTR_REG_VAL_ONF 8'h24
`define DTR_REG_VAL_PLS 8'h28
`define DTR_REG_VAL_BLK 8'h2C

// duration word fields: hours, minutes, seconds, 10 ms units
`define DTR_F_HR 31:22
`define DTR_F_MIN 21:16
`define DTR_F_SEC 13:8
`define DTR_F_CS 6:0
`define DTR_PARAM_MASK 32'hFFFF3F7F
`define DTR_PARAM_RST 32'h00000100
`define DTR_NPARAM 6

// block slots on the pin vectors
`define DTR_NBLK 5
`define DTR_B_OFFD 0
`define DTR_B_ONF 1
`define DTR_B_PLS 2
`define DTR_B_TGL 3
`define DTR_B_BLK 4

// timing: base tick and clock rate
`define DTR_TICK_MS 10
`define DTR_CLK_MHZ 200
`define DTR_HALF_TICK_CYC (`DTR_TICK_MS * 1000 * `DTR_CLK_MHZ / 2)

// bus answers
`define DTR_RESP_OKAY 2'h0
`define DTR_RESP_SLVERR 2'h2

`endif

// [hdl/dtr_pkg.sv]
// Purpose: types shared by the relay timer block and its bench
// Assumes: constants live in dtr_defs.svh
// Notes: bus signals travel as packed structs
package dtr_pkg;

    // master to slave half of the AXI4-Lite port
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } dtr_axi_req_s;

    // slave to master half of the AXI4-Lite port
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } dtr_axi_rsp_s;

    // blinker phases
    typedef enum logic [1:0] {
        BLK_IDLE,
        BLK_HIGH,
        BLK_LOW
    } dtr_blk_e;

endpackage

// [hdl/dtr_top.sv]
// Purpose: five timer relay blocks with AXI4-Lite durations and value words
// Assumes: trigger and reset pins are asynchronous to CLK
// Notes: durations count in 10 ms ticks; the off-delay counts 5 ms half ticks
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "dtr_defs.svh"

// Contract
// - off-delay output follows trigger high at once
// - trigger fall starts off-delay, expiry clears output
// - each trigger fall restarts off-delay from zero
// - off-delay reset clears timer and output first
// - durations held as hours minutes seconds hundredths
// - off-delay error stays within 5 ms
// - on/off rising trigger starts on-delay timing
// - trigger held through on-delay sets output
// - early trigger fall cancels on-delay timing
// - trigger fall starts off-delay, expiry clears output
// - early trigger rise cancels off-delay timing
// - on/off reset clears timings and output first
// - one-shot rising trigger gives pulse of set width
// - one-shot ignores trigger while pulse is high
// - one-shot reset forces output low at once
// - toggle latch inverts on each trigger rise
// - toggle reset wins over same-cycle trigger edge
// - toggle latch clears at power up
// - trigger high at start counts as rise
// - blinker cycles high/low while trigger held
// - timed blocks publish elapsed value continuously
module dtr_top #(
    parameter int unsigned HALF_TICK_CYC = `DTR_HALF_TICK_CYC
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire dtr_pkg::dtr_axi_req_s AXI_REQ,
    output dtr_pkg::dtr_axi_rsp_s AXI_RSP,
    input wire logic [`DTR_NBLK-1:0] TRG_IN,
    input wire logic [`DTR_NBLK-1:0] RST_IN,
    output logic [`DTR_NBLK-1:0] Q_OUT
);
    import dtr_pkg::*;

    // duration word to 10 ms ticks
    function automatic logic [31:0] to_ticks(input logic [31:0] p);
        logic [31:0] h;
        logic [31:0] m;
        logic [31:0] s;
        logic [31:0] c;
        h = {22'h0, p[`DTR_F_HR]};
        m = {26'h0, p[`DTR_F_MIN]};
        s = {26'h0, p[`DTR_F_SEC]};
        c = {25'h0, p[`DTR_F_CS]};
        return ((h * 32'h3C + m) * 32'h3C + s) * 32'h64 + c;
    endfunction

    // writable duration register decode
    function automatic logic is_param(input logic [7:0] a);
        return a[7:2] < 6'(`DTR_NPARAM);
    endfunction

    // byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                          input logic [3:0] st);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = d[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [`DTR_NBLK-1:0] trg_m_q, trg_s, rst_m_q, rst_s, trg_p_q, rise, fall;
    logic [31:0] div_q;
    logic half_q, phase_q, tick;
    logic [31:0] par_q [`DTR_NPARAM];
    logic [31:0] t_offd, t_onh, t_onl, t_pls, t_blh, t_bll;
    logic offd_run_q, offd_q_q;
    logic [31:0] offd_cnt_q;
    logic onf_on_run_q, onf_off_run_q, onf_q_q;
    logic [31:0] onf_cnt_q;
    logic pls_q_q;
    logic [31:0] pls_cnt_q;
    logic tgl_q_q;
    dtr_blk_e blk_st_q;
    logic blk_q_q;
    logic [31:0] blk_cnt_q;
    logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q, rdata_q, rd_word;
    logic [3:0] w_strb_q;
    logic [1:0] bresp_q, rresp_q, rd_resp;
    logic wr_fire;

    // two-flop synchronisers for the asynchronous pins
    generate
        for (genvar i = 0; i < `DTR_NBLK; i++) begin : g_sync
            always_ff @(posedge CLK or posedge SYS_RST) begin
                if (SYS_RST) begin
                    trg_m_q[i] <= 1'b0;
                    trg_s[i] <= 1'b0;
                    rst_m_q[i] <= 1'b0;
                    rst_s[i] <= 1'b0;
                end else begin
                    trg_m_q[i] <= TRG_IN[i];
                    trg_s[i] <= trg_m_q[i];
                    rst_m_q[i] <= RST_IN[i];
                    rst_s[i] <= rst_m_q[i];
                end
            end
        end
    endgenerate

    // previous sample clears to 0, so a trigger high at start reads as a rise
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            trg_p_q <= '0;
        end else begin
            trg_p_q <= trg_s;
        end
    end
    assign rise = trg_s & ~trg_p_q;
    assign fall = ~trg_s & trg_p_q;

    // 5 ms half tick; every second one is the common 10 ms tick
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            div_q <= '0;
            half_q <= 1'b0;
            phase_q <= 1'b0;
        end else begin
            half_q <= (div_q == 32'(HALF_TICK_CYC - 1));
            if (div_q == 32'(HALF_TICK_CYC - 1)) begin
                div_q <= '0;
                phase_q <= ~phase_q;
            end else begin
                div_q <= div_q + 32'h1;
            end
        end
    end
    assign tick = half_q & ~phase_q;

    assign t_offd = to_ticks(par_q[0]);
    assign t_onh = to_ticks(par_q[1]);
    assign t_onl = to_ticks(par_q[2]);
    assign t_pls = to_ticks(par_q[3]);
    assign t_blh = to_ticks(par_q[4]);
    assign t_bll = to_ticks(par_q[5]);

    // off-delay timer; half ticks keep the start-phase error within 5 ms
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            offd_run_q <= 1'b0;
            offd_cnt_q <= '0;
            offd_q_q <= 1'b0;
        end else if (rst_s[`DTR_B_OFFD]) begin
            offd_run_q <= 1'b0;
            offd_cnt_q <= '0;
            offd_q_q <= 1'b0;
        end else if (trg_s[`DTR_B_OFFD]) begin
            offd_run_q <= 1'b0;
            offd_cnt_q <= '0;
            offd_q_q <= 1'b1;
        end else if (fall[`DTR_B_OFFD]) begin
            offd_run_q <= 1'b1;
            offd_cnt_q <= '0;
            offd_q_q <= 1'b1;
        end else if (offd_run_q && half_q) begin
            if (offd_cnt_q + 32'h1 >= {t_offd[30:0], 1'b0}) begin
                offd_run_q <= 1'b0;
                offd_cnt_q <= '0;
                offd_q_q <= 1'b0;
            end else begin
                offd_cnt_q <= offd_cnt_q + 32'h1;
            end
        end
    end

    // on/off-delay timer, one counter shared by both timings
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            onf_on_run_q <= 1'b0;
            onf_off_run_q <= 1'b0;
            onf_cnt_q <= '0;
            onf_q_q <= 1'b0;
        end else if (rst_s[`DTR_B_ONF]) begin
            onf_on_run_q <= 1'b0;
            onf_off_run_q <= 1'b0;
            onf_cnt_q <= '0;
            onf_q_q <= 1'b0;
        end else if (rise[`DTR_B_ONF]) begin
            onf_on_run_q <= 1'b1;
            onf_off_run_q <= 1'b0;
            onf_cnt_q <= '0;
        end else if (fall[`DTR_B_ONF]) begin
            onf_on_run_q <= 1'b0;
            onf_off_run_q <= 1'b1;
            onf_cnt_q <= '0;
        end else if (tick && (onf_on_run_q || onf_off_run_q)) begin
            if (onf_cnt_q + 32'h1 >= (onf_on_run_q ? t_onh : t_onl)) begin
                onf_q_q <= onf_on_run_q;
                onf_on_run_q <= 1'b0;
                onf_off_run_q <= 1'b0;
                onf_cnt_q <= '0;
            end else begin
                onf_cnt_q <= onf_cnt_q + 32'h1;
            end
        end
    end

    // one-shot; a rise only counts while the output is low
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pls_q_q <= 1'b0;
            pls_cnt_q <= '0;
        end else if (rst_s[`DTR_B_PLS]) begin
            pls_q_q <= 1'b0;
            pls_cnt_q <= '0;
        end else if (!pls_q_q && rise[`DTR_B_PLS]) begin
            pls_q_q <= 1'b1;
            pls_cnt_q <= '0;
        end else if (pls_q_q && tick) begin
            if (pls_cnt_q + 32'h1 >= t_pls) begin
                pls_q_q <= 1'b0;
                pls_cnt_q <= '0;
            end else begin
                pls_cnt_q <= pls_cnt_q + 32'h1;
            end
        end
    end

    // toggle latch; power-up reset clears it
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            tgl_q_q <= 1'b0;
        end else if (rst_s[`DTR_B_TGL]) begin
            tgl_q_q <= 1'b0;
        end else if (rise[`DTR_B_TGL]) begin
            tgl_q_q <= ~tgl_q_q;
        end
    end

    // blinker; starts on trigger level so it resumes after reset
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            blk_st_q <= BLK_IDLE;
            blk_q_q <= 1'b0;
            blk_cnt_q <= '0;
        end else if (rst_s[`DTR_B_BLK] || !trg_s[`DTR_B_BLK]) begin
            blk_st_q <= BLK_IDLE;
            blk_q_q <= 1'b0;
            blk_cnt_q <= '0;
        end else begin
            case (blk_st_q)
                BLK_IDLE: begin
                    blk_st_q <= BLK_HIGH;
                    blk_q_q <= 1'b1;
                    blk_cnt_q <= '0;
                end
                BLK_HIGH, BLK_LOW: begin
                    if (tick) begin
                        if (blk_cnt_q + 32'h1 >= (blk_q_q ? t_blh : t_bll)) begin
                            blk_st_q <= blk_q_q ? BLK_LOW : BLK_HIGH;
                            blk_q_q <= ~blk_q_q;
                            blk_cnt_q <= '0;
                        end else begin
                            blk_cnt_q <= blk_cnt_q + 32'h1;
                        end
                    end
                end
                default: begin
                    blk_st_q <= BLK_IDLE;
                    blk_q_q <= 1'b0;
                end
            endcase
        end
    end

    assign Q_OUT = {blk_q_q, tgl_q_q, pls_q_q, onf_q_q, offd_q_q};

    // write channels are captured in either order, then applied together
    assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            bvalid_q <= 1'b0;
            bresp_q <= `DTR_RESP_OKAY;
        end else begin
            if (AXI_REQ.awvalid && AXI_RSP.awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= AXI_REQ.awaddr;
            end
            if (AXI_REQ.wvalid && AXI_RSP.wready) begin
                w_have_q <= 1'b1;
                w_data_q <= AXI_REQ.wdata;
                w_strb_q <= AXI_REQ.wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= is_param(aw_addr_q) ? `DTR_RESP_OKAY : `DTR_RESP_SLVERR;
            end else if (bvalid_q && AXI_REQ.bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // duration registers; unused field bits never store
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            for (int i = 0; i < `DTR_NPARAM; i++) begin
                par_q[i] <= `DTR_PARAM_RST;
            end
        end else if (wr_fire && is_param(aw_addr_q)) begin
            par_q[aw_addr_q[4:2]] <= merge(par_q[aw_addr_q[4:2]], w_data_q, w_strb_q)
                                     & `DTR_PARAM_MASK;
        end
    end

    // read decode; value words are live counters, not snapshots
    always_comb begin
        rd_word = '0;
        rd_resp = `DTR_RESP_OKAY;
        if (is_param(AXI_REQ.araddr)) begin
            rd_word = par_q[AXI_REQ.araddr[4:2]];
        end else begin
            case ({AXI_REQ.araddr[7:2], 2'b00})
                `DTR_REG_STATUS: rd_word = {11'h0, rst_s, 3'h0, trg_s, 3'h0, Q_OUT};
                `DTR_REG_VAL_OFFD: rd_word = {1'b0, offd_cnt_q[31:1]};
                `DTR_REG_VAL_ONF: rd_word = onf_cnt_q;
                `DTR_REG_VAL_PLS: rd_word = pls_cnt_q;
                `DTR_REG_VAL_BLK: rd_word = blk_cnt_q;
                default: rd_resp = `DTR_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= `DTR_RESP_OKAY;
        end else if (AXI_REQ.arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_resp;
        end else if (rvalid_q && AXI_REQ.rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // ready terms are combinational; one write and one read in flight at most
    assign AXI_RSP.awready = !aw_have_q && !bvalid_q;
    assign AXI_RSP.wready = !w_have_q && !bvalid_q;
    assign AXI_RSP.bvalid = bvalid_q;
    assign AXI_RSP.bresp = bresp_q;
    assign AXI_RSP.arready = !rvalid_q;
    assign AXI_RSP.rvalid = rvalid_q;
    assign AXI_RSP.rdata = rdata_q;
    assign AXI_RSP.rresp = rresp_q;

    // checks on the block logic
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    property p_offd_follow;
        trg_s[0] && !rst_s[0] |=> offd_q_q;
    endproperty
    a_offd_follow: assert property (p_offd_follow) else $error("off-delay not high");

    property p_offd_hold;
        fall[0] && !rst_s[0] |=> offd_run_q && offd_q_q && offd_cnt_q == 32'h0;
    endproperty
    a_offd_hold: assert property (p_offd_hold) else $error("off-delay start bad");

    property p_offd_expire;
        offd_run_q && half_q && !trg_s[0] && !rst_s[0]
            && offd_cnt_q + 32'h1 >= {t_offd[30:0], 1'b0} |=> !offd_q_q && !offd_run_q;
    endproperty
    a_offd_expire: assert property (p_offd_expire) else $error("off-delay expiry");

    property p_offd_rst;
        rst_s[0] |=> !offd_q_q && offd_cnt_q == 32'h0;
    endproperty
    a_offd_rst: assert property (p_offd_rst) else $error("off-delay reset");

    property p_onf_set;
        onf_on_run_q && trg_s[1] && tick && !rst_s[1] && onf_cnt_q + 32'h1 >= t_onh
            |=> onf_q_q && !onf_on_run_q;
    endproperty
    a_onf_set: assert property (p_onf_set) else $error("on-delay did not set");

    property p_onf_cancel;
        onf_on_run_q && !trg_s[1] && !rst_s[1] |=> !onf_on_run_q && onf_cnt_q == 32'h0;
    endproperty
    a_onf_cancel: assert property (p_onf_cancel) else $error("on-delay not cancelled");

    property p_onf_rst;
        rst_s[1] |=> !onf_q_q && !onf_on_run_q && !onf_off_run_q;
    endproperty
    a_onf_rst: assert property (p_onf_rst) else $error("on/off reset");

    property p_pls_ignore;
        pls_q_q && rise[2] && !rst_s[2] && !tick |=> pls_cnt_q == $past(pls_cnt_q);
    endproperty
    a_pls_ignore: assert property (p_pls_ignore) else $error("one-shot restarted");

    property p_pls_rst;
        rst_s[2] |=> !pls_q_q;
    endproperty
    a_pls_rst: assert property (p_pls_rst) else $error("one-shot reset");

    property p_tgl_flip;
        rise[3] && !rst_s[3] |=> tgl_q_q != $past(tgl_q_q);
    endproperty
    a_tgl_flip: assert property (p_tgl_flip) else $error("toggle did not flip");

    property p_tgl_rst;
        rst_s[3] |=> !tgl_q_q;
    endproperty
    a_tgl_rst: assert property (p_tgl_rst) else $error("toggle reset");

    property p_blk_stop;
        (!trg_s[4] || rst_s[4]) |=> !blk_q_q && blk_st_q == BLK_IDLE;
    endproperty
    a_blk_stop: assert property (p_blk_stop) else $error("blinker not stopped");

    property p_blk_start;
        trg_s[4] && !rst_s[4] && blk_st_q == BLK_IDLE ##1 trg_s[4] && !rst_s[4] |-> blk_q_q;
    endproperty
    a_blk_start: assert property (p_blk_start) else $error("blinker no start");

    c_offd_expire: cover property (offd_run_q ##1 !offd_run_q && !offd_q_q);
    c_onf_set: cover property ($rose(onf_q_q));
    c_pls_done: cover property (pls_q_q ##1 !pls_q_q);
    c_blk_low: cover property (blk_st_q == BLK_LOW ##1 blk_st_q == BLK_HIGH);

endmodule

// [tb/dtr_pin_src.sv]
// Purpose: input terminals that feed the relay timer pins
// Assumes: pins are plain levels from other blocks or terminals
// Notes: levels move only just after a clock edge
`timescale 1ns/1ps
module dtr_pin_src (
    input wire logic clk,
    output logic [4:0] trg,
    output logic [4:0] rst
);
    // terminals read low until driven
    initial begin
        trg = 5'h00;
        rst = 5'h00;
    end

    // one trigger and reset pair per call; static so the bit index may steer a late assignment
    task put(input int b, input logic t, input logic r);
        @(posedge clk);
        trg[b] <= t;
        rst[b] <= r;
    endtask
endmodule

// [tb/dtr_top_tb_top.sv]
// Purpose: self-checking bench for the relay timer blocks
// Assumes: HALF_TICK_CYC of 4, so one 10 ms tick is 8 cycles
// Notes: timing bounds allow for the two synchroniser stages
`timescale 1ns/1ps
`include "dtr_defs.svh"
module dtr_top_tb_top;
    import dtr_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    dtr_axi_req_s req = '0;
    dtr_axi_rsp_s rsp;
    logic [4:0] trg;
    logic [4:0] rst;
    logic [4:0] q;
    int fail_count = 0;
    int total_checks = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    int n;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    dtr_top #(.HALF_TICK_CYC(4)) DUT (
        .CLK(clk),
        .SYS_RST(sys_rst),
        .AXI_REQ(req),
        .AXI_RSP(rsp),
        .TRG_IN(trg),
        .RST_IN(rst),
        .Q_OUT(q)
    );

    dtr_pin_src src (.clk(clk), .trg(trg), .rst(rst));

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic qis(input int b, input logic v);
        chk("q_out", 32'(v), 32'(q[b]));
    endtask

    task automatic cyc(input int k);
        repeat (k) @(negedge clk);
    endtask

    // bounded wait on an output level; a miss ends the run
    task automatic wait_q(input int b, input logic v, input int lim, output int c);
        c = 0;
        while (q[b] !== v) begin
            @(negedge clk);
            c++;
            if (c > lim) begin
                qis(b, v);
                tally_and_finish();
            end
        end
        total_checks++;
    endtask

    // write: address and data offered together, bready held until bvalid
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        req.awaddr <= a;
        req.wdata <= d;
        req.wstrb <= 4'hF;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                return;
            end
        end
        chk("bvalid", 32'h1, 32'h0);
        tally_and_finish();
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                d = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                return;
            end
        end
        chk("rvalid", 32'h1, 32'h0);
        tally_and_finish();
    endtask

    // reset value, field mask, refused places, then short durations
    task automatic t_regs();
        axi_rd(`DTR_REG_OFFD_T, rd, rs);
        chk("offd_t reset", `DTR_PARAM_RST, rd);
        axi_wr(`DTR_REG_OFFD_T, 32'hFFFFFFFF, rs);
        axi_rd(`DTR_REG_OFFD_T, rd, rs);
        chk("offd_t mask", `DTR_PARAM_MASK, rd);
        axi_wr(`DTR_REG_STATUS, 32'hFFFFFFFF, rs);
        chk("ro bresp", 32'(`DTR_RESP_SLVERR), 32'(rs));
        axi_rd(8'h40, rd, rs);
        chk("unmapped rresp", 32'(`DTR_RESP_SLVERR), 32'(rs));
        chk("unmapped rdata", 32'h0, rd);
        for (int i = 0; i < `DTR_NPARAM; i++) begin
            axi_wr(8'(4 * i), (i < 4) ? 32'h3 : 32'h2, rs);
            chk("param bresp", 32'(`DTR_RESP_OKAY), 32'(rs));
        end
        $display("test regs done");
    endtask

    // off-delay of 3 ticks, 24 cycles; expiry window is one half tick
    task automatic t_offd();
        src.put(0, 1'b1, 1'b0);
        wait_q(0, 1'b1, 4, n);
        src.put(0, 1'b0, 1'b0);
        wait_q(0, 1'b0, 30, n);
        chk("offd delay", 32'h1, 32'(n >= 22 && n <= 28));
        src.put(0, 1'b1, 1'b0);
        src.put(0, 1'b0, 1'b0);
        cyc(10);
        src.put(0, 1'b1, 1'b0);
        src.put(0, 1'b0, 1'b0);
        cyc(16);
        qis(0, 1'b1);
        axi_rd(`DTR_REG_VAL_OFFD, rd, rs);
        chk("offd value", 32'h1, 32'(rd != 0 && rd <= 3));
        wait_q(0, 1'b0, 20, n);
        src.put(0, 1'b1, 1'b0);
        src.put(0, 1'b0, 1'b0);
        cyc(5);
        src.put(0, 1'b1, 1'b1);
        wait_q(0, 1'b0, 4, n);
        cyc(8);
        qis(0, 1'b0);
        src.put(0, 1'b0, 1'b0);
        $display("test off-delay done");
    endtask

    // on and off durations of 3 ticks each
    task automatic t_onf();
        src.put(1, 1'b1, 1'b0);
        cyc(10);
        src.put(1, 1'b0, 1'b0);
        cyc(18);
        qis(1, 1'b0);
        src.put(1, 1'b1, 1'b0);
        wait_q(1, 1'b1, 30, n);
        chk("onf on delay", 32'h1, 32'(n >= 19));
        src.put(1, 1'b0, 1'b0);
        cyc(10);
        src.put(1, 1'b1, 1'b0);
        cyc(18);
        qis(1, 1'b1);
        src.put(1, 1'b0, 1'b0);
        wait_q(1, 1'b0, 30, n);
        chk("onf off delay", 32'h1, 32'(n >= 19));
        src.put(1, 1'b1, 1'b0);
        wait_q(1, 1'b1, 30, n);
        src.put(1, 1'b1, 1'b1);
        wait_q(1, 1'b0, 4, n);
        cyc(30);
        qis(1, 1'b0);
        src.put(1, 1'b0, 1'b0);
        $display("test on-off delay done");
    endtask

    // pulse of 3 ticks; a second rise inside it must not stretch it
    task automatic t_pls();
        src.put(2, 1'b1, 1'b0);
        wait_q(2, 1'b1, 4, n);
        src.put(2, 1'b0, 1'b0);
        cyc(8);
        src.put(2, 1'b1, 1'b0);
        wait_q(2, 1'b0, 30, n);
        // pulse began 9 cycles before this wait; 3 ticks less start phase is 17..24 cycles
        chk("pulse end", 32'h1, 32'(n >= 9 && n <= 16));
        cyc(10);
        qis(2, 1'b0);
        src.put(2, 1'b0, 1'b0);
        src.put(2, 1'b1, 1'b0);
        wait_q(2, 1'b1, 4, n);
        src.put(2, 1'b1, 1'b1);
        wait_q(2, 1'b0, 4, n);
        src.put(2, 1'b0, 1'b0);
        $display("test one-shot done");
    endtask

    // latch entered at 1 from the start-up rise
    task automatic t_tgl();
        src.put(3, 1'b0, 1'b0);
        src.put(3, 1'b1, 1'b0);
        wait_q(3, 1'b0, 6, n);
        src.put(3, 1'b0, 1'b0);
        src.put(3, 1'b1, 1'b1);
        cyc(6);
        qis(3, 1'b0);
        src.put(3, 1'b0, 1'b0);
        src.put(3, 1'b1, 1'b0);
        wait_q(3, 1'b1, 6, n);
        src.put(3, 1'b0, 1'b1);
        wait_q(3, 1'b0, 6, n);
        src.put(3, 1'b0, 1'b0);
        $display("test toggle done");
    endtask

    // blinker of 2 ticks high, 2 ticks low
    task automatic t_blk();
        src.put(4, 1'b1, 1'b0);
        wait_q(4, 1'b1, 4, n);
        wait_q(4, 1'b0, 20, n);
        chk("blink high", 32'h1, 32'(n >= 9));
        wait_q(4, 1'b1, 20, n);
        src.put(4, 1'b1, 1'b1);
        wait_q(4, 1'b0, 4, n);
        cyc(20);
        qis(4, 1'b0);
        src.put(4, 1'b1, 1'b0);
        wait_q(4, 1'b1, 6, n);
        src.put(4, 1'b0, 1'b0);
        wait_q(4, 1'b0, 4, n);
        cyc(20);
        qis(4, 1'b0);
        $display("test blinker done");
    endtask

    // latch trigger already high while reset is held
    initial begin
        src.put(3, 1'b1, 1'b0);
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        qis(3, 1'b0);
        wait_q(3, 1'b1, 6, n);
        t_regs();
        t_offd();
        t_onf();
        t_pls();
        t_tgl();
        t_blk();
        tally_and_finish();
    end
endmodule
